/* File: shared/flash_sec_cfg.svh */
// offsets, field positions, addresses, command bytes and timings of the flash security block
`ifndef FLASH_SEC_CFG_SVH
`define FLASH_SEC_CFG_SVH
`define CLK_PERIOD_NS 4
`define PWR_ON_WAIT_MS 2.76
`define RST_WAIT_MS 1.0
`define MODE_PROG 3'h7
`define MODE_INTERNAL_VECTOR_MODE 3'h0
`define SEC_FA_WORD0 22'h2F8000
`define SEC_FA_WORD1 22'h2FA000
`define SEC_FA_WORD2 22'h2F8004
`define SEC_FA_WORD3 22'h2FA004
`define SEC_FA_LOW_HALF 22'h000002
`define FA_SMALL_BASE 6'h2F
`define FA_LARGE_BASE 6'h30
`define LARGE_SEC_FIRST 5'h08
`define BIT_RD_PROT 16
`define BIT_WR_PROT 17
`define BIT_WP_LEVEL 18
`define CMD_UNLOCK1 8'hAA
`define CMD_UNLOCK2 8'h55
`define CMD_PROGRAM 8'hA0
`define CMD_ERASE 8'h80
`define CMD_SECTOR_ERASE 8'h30
`define CMD_CHIP_ERASE 8'h10
`define CMD_RESET 16'h00F0
`define REG_STATUS 8'h00
`define REG_LOCK_SMALL 8'h04
`define REG_LOCK_LARGE 8'h08
`define REG_BOOT_A 8'h0C
`define REG_BOOT_B 8'h10
`define REG_SECTOR_LOCKS 8'h14
`define ST_DONE 0
`define ST_PROG 1
`define ST_RDBLK 2
`define ST_WPEN 3
`define ST_WPLVL 4
`define ST_RSTWAIT 5
`define ST_PWRWAIT 6
`define ST_VIOL 8
`define ST_BADHI 9
`define ST_MODE_LSB 12
`endif

/* File: shared/flash_sec_pkg.sv */
// state types of the flash security block
package flash_sec_pkg;
    typedef enum logic [2:0] {
        CAP_MODE = 3'b000,
        CAP_ISSUE = 3'b001,
        CAP_BUSY = 3'b010,
        CAP_TAKE = 3'b011,
        CAP_DONE = 3'b100
    } cap_state_t;
    typedef enum logic [2:0] {
        CMD_IDLE = 3'b000,
        CMD_U1 = 3'b001,
        CMD_U2 = 3'b010,
        CMD_PGM = 3'b011,
        CMD_E1 = 3'b100,
        CMD_E2 = 3'b101,
        CMD_E3 = 3'b110
    } cmd_state_t;
endpackage : flash_sec_pkg

/* File: rtl/sector_decode.sv */
// programming-address to sector decoder with lock lookup
`timescale 1ns/1ps
`default_nettype none
`include "flash_sec_cfg.svh"
module sector_decode (
    input wire logic [21:0] addr_i,
    input wire logic [23:0] lock_vec_i,
    output logic [4:0] sector_o,
    output logic valid_o,
    output logic locked_o
);
    // large sectors above the small block, anything else maps nowhere
    always_comb begin
        sector_o = 5'h00;
        valid_o = 1'b0;
        if (addr_i[21:16] >= `FA_LARGE_BASE) begin // [RULE4]
            sector_o = `LARGE_SEC_FIRST + {1'b0, addr_i[19:16]};
            valid_o = 1'b1;
        end else if (addr_i[21:16] == `FA_SMALL_BASE) begin // [RULE4]
            sector_o = {2'b00, addr_i[15:13]};
            valid_o = 1'b1;
        end
    end
    // unmapped targets count as locked so stray writes never land
    assign locked_o = valid_o ? lock_vec_i[sector_o] : 1'b1; // [RULE14]
endmodule : sector_decode
`default_nettype wire

/* File: rtl/flash_sec.sv */
// flash security capture, programming-mode bridge and AHB-Lite status port
// Function
// RULE1: reset with mode pins all high halts the CPU and hands the flash to the port pins.
// RULE2: in programming mode the flash acts as a stand-alone part taking all command sequences.
// RULE3: the programmer keeps address bit 0 low and bit 21 high on every access.
// RULE4: large sectors 8-23 decode from the upper base, small sectors 0-7 from the lower one.
// RULE5: the programmer waits 2.76 ms after power-on before the first flash access.
// RULE6: the programmer waits 1.0 ms after external reset rises before any access.
// RULE7: the two lock words and two boot words are read from four consecutive words; the code reads them at 2F8000, 2FA000, 2F8004 and 2FA004.
// RULE8: lock word small bits 16/17/18 give read, write and level; bits 19-31 stay zero.
// RULE9: read protection blocks flash reads in every mode except internal-vector mode.
// RULE10: level zero applies write protection everywhere, level one all but internal-vector.
// RULE11: with write protection on, small-word bits 0-7 lock small sectors, zero means locked.
// RULE12: with write protection on, large-word bits 0-15 lock sectors 8-23, zero means locked.
// RULE13: the sector holding the lock words must always be written as locked.
// RULE14: program or erase aimed at a locked sector changes nothing; protected reads hide data.
// RULE15: security is captured once at reset, held, and flash stays blocked until then.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "flash_sec_cfg.svh"
module flash_sec #(
    parameter int unsigned PWR_WAIT_CYCLES =
        int'(`PWR_ON_WAIT_MS * 1.0e6 / `CLK_PERIOD_NS),
    parameter int unsigned RST_WAIT_CYCLES =
        int'(`RST_WAIT_MS * 1.0e6 / `CLK_PERIOD_NS)
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic clk_en_i,
    input wire logic [2:0] mode_select_pins_i,
    input wire logic [21:0] prog_address_i,
    input wire logic prog_ce_n_i,
    input wire logic prog_oe_n_i,
    input wire logic prog_we_n_i,
    input wire logic [15:0] prog_dq_i,
    output logic [15:0] prog_dq_o,
    output logic prog_dq_oe_o,
    output logic prog_ready_o,
    output logic [21:0] flash_addr_o,
    output logic flash_rd_o,
    output logic flash_we_o,
    output logic [15:0] flash_wdata_o,
    input wire logic [15:0] flash_rdata_i,
    input wire logic flash_ready_i,
    output logic cpu_halt_o,
    output logic cpu_read_block_o,
    output logic [23:0] cpu_write_lock_o,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o
);
    flash_sec_pkg::cap_state_t cap_st_r;
    flash_sec_pkg::cmd_state_t cmd_st_r;
    logic [2:0] cap_idx_r;
    logic [2:0] mode_r;
    logic [127:0] sec_sr_r;
    logic [31:0] lock_small;
    logic [31:0] lock_large;
    logic [31:0] boot_a;
    logic [31:0] boot_b;
    logic done;
    logic internal_vector_mode;
    logic prog_mode;
    logic wp_en;
    logic read_block;
    logic [23:0] lock_vec;
    logic [21:0] cap_base;
    logic [21:0] cap_addr;
    logic we_q_r;
    logic wr_take;
    logic prog_rd;
    logic prog_rd_q_r;
    logic [4:0] dec_sector;
    logic dec_valid;
    logic dec_locked;
    logic blocked;
    logic viol_r;
    logic viol_clr;
    logic [19:0] wait_cnt_r;
    logic rst_wait_done;
    logic pwr_wait_done;
    logic [21:0] flash_addr_r;
    logic flash_rd_r;
    logic flash_we_r;
    logic [15:0] flash_wdata_r;
    logic [15:0] prog_dq_r;
    logic prog_dq_oe_r;
    logic bus_wr_r;
    logic bus_hit_r;
    logic [7:0] bus_addr_r;
    logic [31:0] hrdata_r;
    logic [31:0] rd_val;
    logic [31:0] status_val;

    // captured words, oldest read sits highest in the shift register
    assign lock_small = sec_sr_r[127:96];
    assign boot_a = sec_sr_r[95:64];
    assign lock_large = sec_sr_r[63:32];
    assign boot_b = sec_sr_r[31:0];
    assign done = (cap_st_r == flash_sec_pkg::CAP_DONE);
    assign internal_vector_mode = (mode_r == `MODE_INTERNAL_VECTOR_MODE);
    assign prog_mode = done && (mode_r == `MODE_PROG);

    // protection decisions; before capture everything counts as locked
    assign read_block = !done || (lock_small[`BIT_RD_PROT] && !internal_vector_mode); // [RULE9] [RULE15]
    assign wp_en = done && lock_small[`BIT_WR_PROT]
        && (!lock_small[`BIT_WP_LEVEL] || !internal_vector_mode); // [RULE10]
    assign lock_vec = {24{!done}}
        | ({24{wp_en}} & ~{lock_large[15:0], lock_small[7:0]}); // [RULE11] [RULE12]

    // cpu side levels; cpu stays off the flash until capture ends
    assign cpu_halt_o = !done || (mode_r == `MODE_PROG); // [RULE1]
    assign cpu_read_block_o = read_block;
    assign cpu_write_lock_o = lock_vec;

    // security word location for the current capture step
    always_comb begin
        case (cap_idx_r[2:1])
            2'h0: cap_base = `SEC_FA_WORD0;
            2'h1: cap_base = `SEC_FA_WORD1;
            2'h2: cap_base = `SEC_FA_WORD2;
            default: cap_base = `SEC_FA_WORD3;
        endcase
        cap_addr = cap_base | (cap_idx_r[0] ? `SEC_FA_LOW_HALF : 22'h000000); // [RULE7]
    end

    // capture: latch mode pins once, then fetch eight half-words
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            cap_st_r <= flash_sec_pkg::CAP_MODE;
            cap_idx_r <= 3'h0;
            mode_r <= 3'h0;
            sec_sr_r <= 128'h0;
        end else if (clk_en_i) begin
            case (cap_st_r)
                flash_sec_pkg::CAP_MODE: begin
                    mode_r <= mode_select_pins_i; // [RULE1]
                    cap_st_r <= flash_sec_pkg::CAP_ISSUE;
                end
                flash_sec_pkg::CAP_ISSUE: cap_st_r <= flash_sec_pkg::CAP_BUSY;
                flash_sec_pkg::CAP_BUSY: cap_st_r <= flash_sec_pkg::CAP_TAKE;
                flash_sec_pkg::CAP_TAKE: begin
                    sec_sr_r <= {sec_sr_r[111:0], flash_rdata_i}; // [RULE7]
                    cap_idx_r <= cap_idx_r + 3'h1;
                    if (cap_idx_r == 3'h7) begin
                        cap_st_r <= flash_sec_pkg::CAP_DONE; // [RULE15]
                    end else begin
                        cap_st_r <= flash_sec_pkg::CAP_ISSUE;
                    end
                end
                default: cap_st_r <= flash_sec_pkg::CAP_DONE;
            endcase
        end
    end

    // informative wait counters; the programmer owns the waiting itself
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            wait_cnt_r <= 20'h00000;
        end else if (clk_en_i && !pwr_wait_done) begin
            wait_cnt_r <= wait_cnt_r + 20'h00001;
        end
    end
    assign rst_wait_done = (wait_cnt_r >= 20'(RST_WAIT_CYCLES)); // [RULE6]
    assign pwr_wait_done = (wait_cnt_r >= 20'(PWR_WAIT_CYCLES)); // [RULE5]

    // pin strobes; pins are synchronous, write taken on we falling edge
    assign wr_take = prog_mode && !prog_ce_n_i && !prog_we_n_i && we_q_r; // [RULE2]
    assign prog_rd = prog_mode && !prog_ce_n_i && !prog_oe_n_i && prog_we_n_i;
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            we_q_r <= 1'b1;
        end else if (clk_en_i) begin
            we_q_r <= prog_we_n_i;
        end
    end

    sector_decode u_dec (
        .addr_i(prog_address_i),
        .lock_vec_i(lock_vec),
        .sector_o(dec_sector),
        .valid_o(dec_valid),
        .locked_o(dec_locked)
    );

    // final write of a sequence is swapped for a reset when its target is locked
    always_comb begin
        blocked = 1'b0;
        if (cmd_st_r == flash_sec_pkg::CMD_PGM) begin
            blocked = dec_locked; // [RULE14]
        end else if (cmd_st_r == flash_sec_pkg::CMD_E3) begin
            if (prog_dq_i[7:0] == `CMD_SECTOR_ERASE) begin
                blocked = dec_locked; // [RULE14]
            end else if (prog_dq_i[7:0] == `CMD_CHIP_ERASE) begin
                blocked = |lock_vec; // [RULE14]
            end
        end
    end

    // command sequence tracker, only to spot the final write
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            cmd_st_r <= flash_sec_pkg::CMD_IDLE;
        end else if (clk_en_i && wr_take) begin
            case (cmd_st_r)
                flash_sec_pkg::CMD_IDLE: cmd_st_r <= (prog_dq_i[7:0] == `CMD_UNLOCK1)
                    ? flash_sec_pkg::CMD_U1 : flash_sec_pkg::CMD_IDLE;
                flash_sec_pkg::CMD_U1: cmd_st_r <= (prog_dq_i[7:0] == `CMD_UNLOCK2)
                    ? flash_sec_pkg::CMD_U2 : flash_sec_pkg::CMD_IDLE;
                flash_sec_pkg::CMD_U2: begin
                    if (prog_dq_i[7:0] == `CMD_PROGRAM) begin
                        cmd_st_r <= flash_sec_pkg::CMD_PGM;
                    end else if (prog_dq_i[7:0] == `CMD_ERASE) begin
                        cmd_st_r <= flash_sec_pkg::CMD_E1;
                    end else begin
                        cmd_st_r <= flash_sec_pkg::CMD_IDLE;
                    end
                end
                flash_sec_pkg::CMD_E1: cmd_st_r <= (prog_dq_i[7:0] == `CMD_UNLOCK1)
                    ? flash_sec_pkg::CMD_E2 : flash_sec_pkg::CMD_IDLE;
                flash_sec_pkg::CMD_E2: cmd_st_r <= (prog_dq_i[7:0] == `CMD_UNLOCK2)
                    ? flash_sec_pkg::CMD_E3 : flash_sec_pkg::CMD_IDLE;
                default: cmd_st_r <= flash_sec_pkg::CMD_IDLE;
            endcase
        end
    end

    // flash array port, shared by capture and the pins
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            flash_addr_r <= 22'h000000;
            flash_rd_r <= 1'b0;
            flash_we_r <= 1'b0;
            flash_wdata_r <= 16'h0000;
        end else if (clk_en_i) begin
            flash_rd_r <= (cap_st_r == flash_sec_pkg::CAP_ISSUE) || prog_rd;
            flash_we_r <= wr_take; // [RULE2] [RULE15]
            if (cap_st_r == flash_sec_pkg::CAP_ISSUE) begin
                flash_addr_r <= cap_addr;
            end else begin
                flash_addr_r <= prog_address_i; // [RULE1]
            end
            flash_wdata_r <= blocked ? `CMD_RESET : prog_dq_i; // [RULE14]
        end
    end
    assign flash_addr_o = flash_addr_r;
    assign flash_rd_o = flash_rd_r;
    assign flash_we_o = flash_we_r;
    assign flash_wdata_o = flash_wdata_r;

    // read return to the pins; protected reads give zeros
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            prog_rd_q_r <= 1'b0;
            prog_dq_r <= 16'h0000;
            prog_dq_oe_r <= 1'b0;
        end else if (clk_en_i) begin
            prog_rd_q_r <= flash_rd_r && prog_mode;
            prog_dq_oe_r <= prog_rd_q_r;
            if (prog_rd_q_r) begin
                prog_dq_r <= read_block ? 16'h0000 : flash_rdata_i; // [RULE9] [RULE14]
            end
        end
    end
    assign prog_dq_o = prog_dq_r;
    assign prog_dq_oe_o = prog_dq_oe_r;
    assign prog_ready_o = flash_ready_i && done; // busy shown while capturing

    // sticky refused-write flag; a new event beats a clear in the same cycle
    assign viol_clr = bus_wr_r && bus_hit_r && (bus_addr_r == `REG_STATUS)
        && hwdata_i[`ST_VIOL];
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            viol_r <= 1'b0;
        end else if (clk_en_i) begin
            if (wr_take && blocked) begin
                viol_r <= 1'b1;
            end else if (viol_clr) begin
                viol_r <= 1'b0;
            end
        end
    end

    // status word
    always_comb begin
        status_val = 32'h00000000;
        status_val[`ST_DONE] = done;
        status_val[`ST_PROG] = prog_mode;
        status_val[`ST_RDBLK] = read_block;
        status_val[`ST_WPEN] = wp_en;
        status_val[`ST_WPLVL] = lock_small[`BIT_WP_LEVEL];
        status_val[`ST_RSTWAIT] = rst_wait_done;
        status_val[`ST_PWRWAIT] = pwr_wait_done;
        status_val[`ST_VIOL] = viol_r;
        status_val[`ST_BADHI] = |lock_small[31:19]; // [RULE8]
        status_val[`ST_MODE_LSB +: 3] = mode_r;
    end

    // register read decode on the address phase
    always_comb begin
        rd_val = 32'h00000000;
        if (haddr_i[31:8] != 24'h000000) begin
            rd_val = 32'h00000000;
        end else if (haddr_i[7:0] == `REG_STATUS) begin
            rd_val = status_val;
        end else if (haddr_i[7:0] == `REG_LOCK_SMALL) begin
            rd_val = lock_small;
        end else if (haddr_i[7:0] == `REG_LOCK_LARGE) begin
            rd_val = lock_large;
        end else if (haddr_i[7:0] == `REG_BOOT_A) begin
            rd_val = boot_a;
        end else if (haddr_i[7:0] == `REG_BOOT_B) begin
            rd_val = boot_b;
        end else if (haddr_i[7:0] == `REG_SECTOR_LOCKS) begin
            rd_val = {8'h00, lock_vec};
        end
    end

    // ahb-lite slave, zero wait states, always okay
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            bus_wr_r <= 1'b0;
            bus_hit_r <= 1'b0;
            bus_addr_r <= 8'h00;
            hrdata_r <= 32'h00000000;
        end else if (clk_en_i) begin
            bus_wr_r <= 1'b0;
            if (hsel_i && htrans_i[1] && hready_i) begin
                bus_wr_r <= hwrite_i;
                bus_hit_r <= (haddr_i[31:8] == 24'h000000) && (hsize_i == 3'h2);
                bus_addr_r <= haddr_i[7:0];
                if (!hwrite_i) begin
                    hrdata_r <= rd_val;
                end
            end
        end
    end
    assign hrdata_o = hrdata_r;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    property p_halt;
        done |-> (cpu_halt_o == (mode_r == `MODE_PROG)) && (prog_mode == cpu_halt_o);
    endproperty
    a_halt: assert property (p_halt) else $error("cpu halt disagrees with mode"); // [RULE1]
    property p_pass;
        clk_en_i && wr_take && !blocked |=> flash_we_o && flash_wdata_o == $past(prog_dq_i);
    endproperty
    a_pass: assert property (p_pass) else $error("pin write not forwarded"); // [RULE2]
    property p_small_dec;
        prog_address_i[21:16] == `FA_SMALL_BASE |-> dec_valid && dec_sector[4:3] == 2'b00;
    endproperty
    a_small_dec: assert property (p_small_dec) else $error("small sector misdecoded"); // [RULE4]
    property p_cap_addr;
        cap_st_r == flash_sec_pkg::CAP_BUSY |-> flash_rd_o && flash_addr_o[21:14] == 8'hBE;
    endproperty
    a_cap_addr: assert property (p_cap_addr) else $error("capture read off target"); // [RULE7]
    property p_rdprot;
        prog_dq_oe_o && done && lock_small[`BIT_RD_PROT] && !internal_vector_mode |-> prog_dq_o == 16'h0000;
    endproperty
    a_rdprot: assert property (p_rdprot) else $error("protected data leaked"); // [RULE9]
    property p_level;
        done && lock_small[`BIT_WR_PROT] && !lock_small[`BIT_WP_LEVEL]
            |-> cpu_write_lock_o == ~{lock_large[15:0], lock_small[7:0]};
    endproperty
    a_level: assert property (p_level) else $error("level zero lock wrong"); // [RULE10]
    property p_nolock;
        done && !lock_small[`BIT_WR_PROT] |-> cpu_write_lock_o == 24'h000000;
    endproperty
    a_nolock: assert property (p_nolock) else $error("locks without protection"); // [RULE12]
    property p_block;
        clk_en_i && wr_take && blocked |=> flash_wdata_o == `CMD_RESET && viol_r;
    endproperty
    a_block: assert property (p_block) else $error("locked sector not shielded"); // [RULE14]
    property p_init;
        !done |-> !flash_we_o && !prog_dq_oe_o && cpu_read_block_o;
    endproperty
    a_init: assert property (p_init) else $error("access before capture"); // [RULE15]
    property p_frozen;
        done && $past(done) |-> $stable(sec_sr_r);
    endproperty
    a_frozen: assert property (p_frozen) else $error("security words changed"); // [RULE15]
    c_done: cover property ($rose(done));
    c_write: cover property (wr_take && !blocked ##1 flash_we_o);
    c_blocked: cover property (wr_take && blocked);
    c_read: cover property (prog_dq_oe_o && !read_block);
endmodule : flash_sec
`default_nettype wire

/* File: verif/flash_array_model.sv */
// behavioural flash array holding the security words, with a busy phase after each write
`timescale 1ns/1ps
`default_nettype none
module flash_array_model #(
    parameter int BUSY_CYCLES = 3
) (
    input wire logic clk_i,
    input wire logic [21:0] addr_i,
    input wire logic rd_i,
    input wire logic we_i,
    input wire logic [15:0] wdata_i,
    input wire logic [31:0] word_small_i,
    input wire logic [31:0] word_large_i,
    input wire logic [31:0] word_boot_a_i,
    input wire logic [31:0] word_boot_b_i,
    output logic [15:0] rdata_o,
    output logic ready_o,
    output logic [21:0] last_addr_o,
    output logic [15:0] last_data_o
);
    int busy_cnt;
    logic [31:0] sel_word;
    // four words in small sectors 4 and 5, high half at +0, low half at +2
    always_comb begin
        case (addr_i & 22'h3FFFFD)
            22'h2F8000: sel_word = word_small_i;
            22'h2FA000: sel_word = word_boot_a_i;
            22'h2F8004: sel_word = word_large_i;
            22'h2FA004: sel_word = word_boot_b_i;
            default: sel_word = {2{addr_i[15:0] ^ 16'hA5C3}};
        endcase
    end
    initial begin
        rdata_o = 16'h5A5A;
        busy_cnt = 0;
    end
    // data valid only after a read strobe; toggles otherwise to expose stale use
    always @(posedge clk_i) begin
        rdata_o <= rd_i ? (addr_i[1] ? sel_word[15:0] : sel_word[31:16]) : ~rdata_o;
        if (we_i) begin
            last_addr_o <= addr_i;
            last_data_o <= wdata_i;
            busy_cnt <= BUSY_CYCLES;
        end else if (busy_cnt > 0) begin
            busy_cnt <= busy_cnt - 1;
        end
    end
    assign ready_o = (busy_cnt == 0);
endmodule : flash_array_model
`default_nettype wire

/* File: verif/tb.sv */
// self-checking bench for the flash security block
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [31:0] BOOT_A = 32'h1234ABCD;
    localparam logic [31:0] BOOT_B = 32'h0F0F5A5A;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] mode = 3'h7;
    logic [21:0] pa = 22'h200000;
    logic ce_n = 1'b1;
    logic oe_n = 1'b1;
    logic we_n = 1'b1;
    logic [15:0] dq = 16'h0000;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] w_small = 32'h0;
    logic [31:0] w_large = 32'h0;
    logic [15:0] dq_o, f_wdata, f_rdata, last_data;
    logic dq_oe, p_rdy, f_rd, f_we, f_rdy, halt, rblk, hready, hresp;
    logic [21:0] f_addr, last_addr;
    logic [23:0] wlock;
    logic [31:0] hrdata, r;
    int miscompares = 0;
    int cmp_count = 0;
    flash_sec #(.PWR_WAIT_CYCLES(40), .RST_WAIT_CYCLES(20)) flash_sec_inst (
        .core_clk_i(core_clk), .rst_i(rst), .clk_en_i(1'b1), .mode_select_pins_i(mode),
        .prog_address_i(pa), .prog_ce_n_i(ce_n), .prog_oe_n_i(oe_n), .prog_we_n_i(we_n),
        .prog_dq_i(dq), .prog_dq_o(dq_o), .prog_dq_oe_o(dq_oe), .prog_ready_o(p_rdy),
        .flash_addr_o(f_addr), .flash_rd_o(f_rd), .flash_we_o(f_we), .flash_wdata_o(f_wdata),
        .flash_rdata_i(f_rdata), .flash_ready_i(f_rdy), .cpu_halt_o(halt),
        .cpu_read_block_o(rblk), .cpu_write_lock_o(wlock), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
        .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp));
    flash_array_model flash_array_model_inst (
        .clk_i(core_clk), .addr_i(f_addr), .rd_i(f_rd), .we_i(f_we), .wdata_i(f_wdata),
        .word_small_i(w_small), .word_large_i(w_large), .word_boot_a_i(BOOT_A),
        .word_boot_b_i(BOOT_B), .rdata_o(f_rdata), .ready_o(f_rdy),
        .last_addr_o(last_addr), .last_data_o(last_data));
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            miscompares++;
        end
    endtask : chk
    // bounded wait; a timeout fails the run
    task automatic wait_for(ref logic s, input int lim);
        int n;
        n = 0;
        @(posedge core_clk);
        while (s !== 1'b1) begin
            n++;
            if (n > lim) begin
                miscompares++;
                report_and_stop();
            end
            @(posedge core_clk);
        end
    endtask : wait_for
    // one single word transfer: address phase, then data phase
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        wait_for(hready, 50);
        htrans <= 2'b00;
        hwdata <= wd;
        wait_for(hready, 50);
        rd = hrdata;
    endtask : ahb
    // programmer write strobe, gated on ready
    task automatic pwr(input logic [21:0] a, input logic [15:0] d);
        wait_for(p_rdy, 100);
        pa <= a;
        dq <= d;
        ce_n <= 1'b0;
        we_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        we_n <= 1'b1;
        ce_n <= 1'b1;
        @(posedge core_clk);
    endtask : pwr
    task automatic prd(input logic [21:0] a, output logic [15:0] d);
        wait_for(p_rdy, 100);
        pa <= a;
        ce_n <= 1'b0;
        oe_n <= 1'b0;
        wait_for(dq_oe, 20);
        @(posedge core_clk);
        d = dq_o;
        ce_n <= 1'b1;
        oe_n <= 1'b1;
    endtask : prd
    // unlock prefix then the final program or erase write
    task automatic cmd(input logic erase, input logic [21:0] a, input logic [15:0] d);
        pwr(22'h2F0AAA, 16'h00AA);
        pwr(22'h2F0554, 16'h0055);
        pwr(22'h2F0AAA, erase ? 16'h0080 : 16'h00A0);
        if (erase) begin
            pwr(22'h2F0AAA, 16'h00AA);
            pwr(22'h2F0554, 16'h0055);
        end
        pwr(a, d);
    endtask : cmd
    // reset into a mode with given lock words; the programmer then waits its start-up time
    task automatic cfg(input logic [2:0] m, input logic [31:0] s, input logic [31:0] l);
        logic [31:0] exp [5];
        logic wp;
        logic rb;
        wp = s[17] && !(s[18] && m == 3'h0);
        rb = s[16] && m != 3'h0;
        exp = '{s, l, BOOT_A, BOOT_B, {8'h00, wp ? ~{l[15:0], s[7:0]} : 24'h0}};
        rst <= 1'b1;
        mode <= m;
        w_small <= s;
        w_large <= l;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        chk("lock before capture", 32'h00FFFFFF, {8'h00, wlock});
        chk("block before capture", 32'h1, {31'h0, rblk});
        wait_for(p_rdy, 200);
        repeat (60) @(posedge core_clk);
        ahb(1'b0, 32'h0, 32'h0, r);
        chk("status", {17'h0, m, 2'b00, s[31:19] != 13'h0, 2'b00, 2'b11, s[18], wp, rb,
            m == 3'h7, 1'b1}, r);
        for (int i = 0; i < 5; i++) begin
            ahb(1'b0, 32'h4 + 32'(4 * i), 32'h0, r);
            chk("captured word", exp[i], r);
        end
        chk("write locks", exp[4], {8'h00, wlock});
        chk("read block, okay", {31'h0, rb}, {30'h0, hresp, rblk});
        chk("cpu halt", {31'h0, m == 3'h7}, {31'h0, halt});
    endtask : cfg
    initial begin
        repeat (90000) @(posedge core_clk);
        miscompares++;
        report_and_stop();
    end
    initial begin
        logic [15:0] d;
        @(posedge core_clk);
        // write protection, sectors 4 and 8 locked
        cfg(3'h7, 32'h000200EF, 32'h0000FFFE);
        ahb(1'b1, 32'h4, 32'hFFFFFFFF, r);
        ahb(1'b0, 32'h4, 32'h0, r);
        chk("read-only word", 32'h000200EF, r);
        ahb(1'b0, 32'h40, 32'h0, r);
        chk("unmapped read", 32'h0, r);
        cmd(1'b0, 22'h2FA100, 16'hBEEF);
        chk("program data", 32'h0000BEEF, {16'h0, last_data});
        chk("program addr", 32'h002FA100, {10'h0, last_addr});
        cmd(1'b0, 22'h2F8100, 16'h1234);
        chk("locked program", 32'h000000F0, {16'h0, last_data});
        ahb(1'b0, 32'h0, 32'h0, r);
        chk("refused flag", 32'h1, {31'h0, r[8]});
        ahb(1'b1, 32'h0, 32'h00000100, r);
        ahb(1'b0, 32'h0, 32'h0, r);
        chk("flag cleared", 32'h0, {31'h0, r[8]});
        cmd(1'b1, 22'h300000, 16'h0030);
        chk("locked erase", 32'h000000F0, {16'h0, last_data});
        cmd(1'b1, 22'h3F0000, 16'h0030);
        chk("erase data", 32'h00000030, {16'h0, last_data});
        chk("erase addr", 32'h003F0000, {10'h0, last_addr});
        cmd(1'b1, 22'h300000, 16'h0010);
        chk("chip erase", 32'h000000F0, {16'h0, last_data});
        prd(22'h2F2010, d);
        chk("open read", {16'h0, 16'h2010 ^ 16'hA5C3}, {16'h0, d});
        // read protection only: data hidden, writes pass
        cfg(3'h7, 32'h0001FFEF, 32'h00000000);
        prd(22'h2F2010, d);
        chk("protected read", 32'h0, {16'h0, d});
        cmd(1'b0, 22'h300010, 16'h0BAD);
        chk("unlocked program", 32'h00000BAD, {16'h0, last_data});
        // internal-vector mode with level one, then level zero with a stray high bit
        cfg(3'h0, 32'h0007FF00, 32'h00000000);
        cfg(3'h0, 32'h000A00EF, 32'h0000FF00);
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
